/* File: bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import csl_pkg::*;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [12:0] vbat_mv_in = 13'd3700;
  logic [6:0]  cap_pct_in = 7'd80;
  logic [10:0] ntc_mv_in = 11'd900;
  logic        vin_ok_in = 1'b0;
  logic        taper_in = 1'b0;
  logic [3:0]  fault_in = 4'h0;
  logic [1:0]  lamp_count_in = 2'h3;
  logic [1:0]  sel_pin = 2'h2;
  logic [1:0]  cv_select_in = 2'h2;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        charge_en_out;
  logic [2:0]  charge_phase_out;
  logic [9:0]  charge_current_ma_out;
  logic [12:0] cv_target_mv_out;
  logic        boost_en_out;
  logic [3:0]  lamps;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          checked = 0;

  // blink half period shortened to four cycles
  csl_top #(.BLINK_HALF_CYCLES(4)) uut (
    .clock_in(clock_in), .srst_in(srst_in), .vbat_mv_in(vbat_mv_in),
    .cap_pct_in(cap_pct_in), .ntc_mv_in(ntc_mv_in), .vin_ok_in(vin_ok_in),
    .taper_in(taper_in), .fault_in(fault_in), .lamp_count_in(lamp_count_in),
    .charge_current_select_pin_in(sel_pin), .cv_select_in(cv_select_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .charge_en_out(charge_en_out), .charge_phase_out(charge_phase_out),
    .charge_current_ma_out(charge_current_ma_out),
    .cv_target_mv_out(cv_target_mv_out), .boost_en_out(boost_en_out),
    .indicator_lamp_1_out(lamps[0]), .indicator_lamp_2_out(lamps[1]),
    .indicator_lamp_3_out(lamps[2]), .indicator_lamp_4_out(lamps[3]));

  // free running clock
  always #5 clock_in = ~clock_in;

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic conclude;
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // reset with a new lamp strap; straps settle before release
  task automatic do_reset(input logic [1:0] cnt);
    lamp_count_in <= cnt;
    srst_in <= 1'b1;
    cyc(16);
    srst_in <= 1'b0;
    cyc(6);
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    er = pslverr_out;
    chk({31'h0, pready_out}, 32'h1, "apb answer");
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    // idle edge so a following setup never re-raises psel in this time step
    @(posedge clock_in);
  endtask

  task automatic drive(input logic [12:0] v, input logic [6:0] c, input logic [10:0] t,
                       input logic vin);
    vbat_mv_in <= v;
    cap_pct_in <= c;
    ntc_mv_in <= t;
    vin_ok_in <= vin;
    cyc(10);
  endtask

  // watch lamps for two slow blink periods: steady bits and rising edges
  task automatic lamp_chk(input logic [3:0] exp, input logic [3:0] blk, input int rises);
    logic [3:0] s0, s1, prev;
    int r;
    s0 = 4'h0;
    s1 = 4'h0;
    r = 0;
    prev = lamps;
    repeat (32) begin
      @(negedge clock_in);
      s0 = s0 | ~lamps;
      s1 = s1 | lamps;
      if (((lamps & ~prev) & blk) != 4'h0) r++;
      prev = lamps;
    end
    chk({28'h0, s1}, {28'h0, exp | blk}, "lamps lit");
    chk({28'h0, s0}, {28'h0, ~exp | blk}, "lamps dark");
    chk(r, rises, "blink rate");
    // return on a rising edge so the next stimulus lands there
    @(posedge clock_in);
  endtask

  task automatic t_regs;
    chk({19'h0, cv_target_mv_out}, 32'd4350, "cv target");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h3, "ctrl reset");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'd500, "limit reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    // boost request bit cleared and set again over the bus
    apb(1'b1, 12'h000, 32'h1);
    cyc(3);
    chk({31'h0, boost_en_out}, 32'h0, "boost request off");
    apb(1'b1, 12'h000, 32'h3);
  endtask

  task automatic t_boost;
    logic [10:0] nt[4] = '{11'd1470, 11'd1471, 11'd440, 11'd439};
    for (int i = 0; i < 4; i++) begin
      drive(13'd3700, 7'd80, nt[i], 1'b0);
      chk({31'h0, boost_en_out}, {31'h0, ~i[0]}, "boost ntc");
    end
    drive(13'd3700, 7'd80, 11'd900, 1'b0);
    for (int i = 0; i < 4; i++) begin
      fault_in <= 4'h1 << i;
      cyc(6);
      chk({31'h0, boost_en_out}, 32'h0, "boost fault");
    end
    fault_in <= 4'h0;
    cyc(6);
    chk({31'h0, boost_en_out}, 32'h1, "boost back");
  endtask

  task automatic t_disp(input logic [6:0] c0, c1, c2, input logic [3:0] e0, e1);
    drive(13'd3700, c0, 11'd900, 1'b0);
    lamp_chk(e0 | e1 | 4'h1, 4'h0, 0);
    drive(13'd3700, c1, 11'd900, 1'b0);
    lamp_chk(e1 | 4'h1, 4'h0, 0);
    drive(13'd3700, c2, 11'd900, 1'b0);
    lamp_chk(4'h1, 4'h0, 0);
    drive(13'd3700, 7'd2, 11'd900, 1'b0);
    lamp_chk(4'h0, 4'h1, 4);
  endtask

  task automatic t_charge;
    drive(13'd2999, 7'd60, 11'd900, 1'b1);
    chk(charge_phase_out, CSL_PRE, "precharge");
    chk(charge_current_ma_out, 10'd35, "tenth current");
    chk({31'h0, charge_en_out}, 32'h1, "charging");
    chk({31'h0, boost_en_out}, 32'h0, "low battery no boost");
    lamp_chk(4'h3, 4'h4, 2);
    drive(13'd3500, 7'd60, 11'd900, 1'b1);
    chk(charge_phase_out, CSL_CC, "cc");
    chk(charge_current_ma_out, 10'd350, "strap current");
    chk({31'h0, boost_en_out}, 32'h1, "both paths");
    apb(1'b1, 12'h004, 32'd200);
    cyc(6);
    chk(charge_current_ma_out, 10'd200, "limited current");
    apb(1'b1, 12'h004, 32'd500);
    drive(13'd4300, 7'd90, 11'd900, 1'b1);
    chk(charge_phase_out, CSL_CV, "cv");
    taper_in <= 1'b1;
    cyc(8);
    chk(charge_phase_out, CSL_FULL, "full");
    chk({31'h0, charge_en_out}, 32'h0, "full stops");
    lamp_chk(4'hf, 4'h0, 0);
    taper_in <= 1'b0;
    drive(13'd4050, 7'd90, 11'd900, 1'b1);
    chk(charge_phase_out, CSL_CC, "recharge");
    drive(13'd3500, 7'd60, 11'd1301, 1'b1);
    chk(charge_phase_out, CSL_OFF, "cold stop");
    drive(13'd3500, 7'd60, 11'd1300, 1'b1);
    chk(charge_phase_out, CSL_CC, "cold edge");
    drive(13'd3500, 7'd60, 11'd499, 1'b1);
    chk(charge_phase_out, CSL_OFF, "hot stop");
    chk({31'h0, charge_en_out}, 32'h0, "hot no charge");
  endtask

  // watchdog sized well above the full sequence
  initial begin
    #400000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    do_reset(2'h3);
    t_regs();
    t_disp(7'd80, 7'd30, 7'd10, 4'hc, 4'h2);
    drive(13'd3700, 7'd60, 11'd900, 1'b0);
    lamp_chk(4'h7, 4'h0, 0);
    t_boost();
    t_charge();
    do_reset(2'h2);
    t_disp(7'd70, 7'd40, 7'd10, 4'h4, 4'h2);
    drive(13'd3500, 7'd40, 11'd900, 1'b1);
    lamp_chk(4'h1, 4'h2, 2);
    do_reset(2'h1);
    drive(13'd3700, 7'd50, 11'd900, 1'b0);
    lamp_chk(4'h2, 4'h0, 0);
    drive(13'd3700, 7'd2, 11'd900, 1'b0);
    lamp_chk(4'h0, 4'h2, 4);
    drive(13'd3500, 7'd50, 11'd900, 1'b1);
    lamp_chk(4'h0, 4'h1, 2);
    do_reset(2'h0);
    drive(13'd3700, 7'd50, 11'd900, 1'b0);
    lamp_chk(4'h1, 4'h0, 0);
    drive(13'd3700, 7'd2, 11'd900, 1'b0);
    lamp_chk(4'h0, 4'h1, 4);
    drive(13'd3500, 7'd50, 11'd900, 1'b1);
    lamp_chk(4'h0, 4'h1, 2);
    conclude();
  end
endmodule // tb_top

/* File: rtl/csl_defs.svh */
`ifndef CSL_DEFS_SVH
`define CSL_DEFS_SVH
// clock and blink timing
`define CSL_CLK_NS        10
`define CSL_BLINK_HALF_MS 500
// battery thresholds in mV
`define CSL_PRE_MV    13'd3000
`define CSL_RECHG_MV  13'd4100
`define CSL_BOTH_MV   13'd3300
`define CSL_PRIO_MV   13'd3100
`define CSL_CV_MARGIN 13'd50
`define CSL_CV0_MV    13'd4200
`define CSL_CV1_MV    13'd4300
`define CSL_CV2_MV    13'd4350
`define CSL_CV3_MV    13'd4400
// temperature sense thresholds in mV
`define CSL_NTC_CCOLD 11'd1300
`define CSL_NTC_CHOT  11'd500
`define CSL_NTC_DCOLD 11'd1470
`define CSL_NTC_DHOT  11'd440
// charge current in mA
`define CSL_CC_MAX  10'd500
`define CSL_CC0_MA  10'd100
`define CSL_CC1_MA  10'd200
`define CSL_CC2_MA  10'd350
`define CSL_CC3_MA  10'd500
`define CSL_PRE_DIV 10'd10
// capacity bands in percent
`define CSL_P75 7'd75
`define CSL_P66 7'd66
`define CSL_P50 7'd50
`define CSL_P33 7'd33
`define CSL_P25 7'd25
`define CSL_P3  7'd3
// apb register map
`define CSL_A_CTRL   12'h000
`define CSL_A_LIMIT  12'h004
`define CSL_A_STATUS 12'h008
`define CSL_CTRL_RST 2'h3
`endif

/* File: rtl/csl_pkg.sv */
package csl_pkg;
  // charger phase
  typedef enum logic [2:0] {
    CSL_OFF,
    CSL_PRE,
    CSL_CC,
    CSL_CV,
    CSL_FULL
  } csl_phase_t;
endpackage

/* File: rtl/csl_top.sv */
// Contract
// - below 3 V precharge at tenth current
// - above 3 V go constant current
// - near target voltage go constant voltage
// - after full, recharge below 4.1 V
// - current from strap, limited, max 500mA
// - above 3.3 V charge and boost together
// - below 3.1 V charging wins over boost
// - lamp count detected, pattern set chosen
// - four lamps discharge capacity bar
// - four lamps low: lamp 1 blinks 1Hz
// - four lamps charge band blinks 0.5Hz
// - three lamps discharge capacity bar
// - three lamps low: lamp 1 blinks 1Hz
// - three lamps charge band blinks 0.5Hz
// - two lamps: charge lamp, discharge lamp
// - one lamp shows charge and discharge
// - charging stops above 1.3 V sense
// - charging stops below 0.5 V sense
// - boost stops above 1.47 V sense
// - boost stops below 0.44 V sense
// - faults disable boost output
`timescale 1ns/1ns
`include "csl_defs.svh"
module csl_top
  import csl_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = `CSL_BLINK_HALF_MS * 1000000 / `CSL_CLK_NS
) (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic [12:0] vbat_mv_in,
  input  wire logic [6:0]  cap_pct_in,
  input  wire logic [10:0] ntc_mv_in,
  input  wire logic        vin_ok_in,
  input  wire logic        taper_in,
  input  wire logic [3:0]  fault_in,
  input  wire logic [1:0]  lamp_count_in,
  input  wire logic [1:0]  charge_current_select_pin_in,
  input  wire logic [1:0]  cv_select_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             charge_en_out,
  output logic [2:0]       charge_phase_out,
  output logic [9:0]       charge_current_ma_out,
  output logic [12:0]      cv_target_mv_out,
  output logic             boost_en_out,
  output logic             indicator_lamp_1_out,
  output logic             indicator_lamp_2_out,
  output logic             indicator_lamp_3_out,
  output logic             indicator_lamp_4_out
);

  // two-flop synchronisers for pin level inputs
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  always_ff @(posedge clock_in) begin
    sync1_reg <= {fault_in, vin_ok_in, taper_in, lamp_count_in,
                  charge_current_select_pin_in, cv_select_in};
    sync2_reg <= sync1_reg;
  end
  wire logic       fault_any = |sync2_reg[11:8];
  wire logic       vin_ok    = sync2_reg[7];
  wire logic       taper     = sync2_reg[6];

  // strap capture once after reset release
  logic       strap_ok_reg;
  logic [1:0] lamp_n_reg;
  logic [1:0] cc_sel_reg;
  logic [1:0] cv_sel_reg;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      strap_ok_reg <= 1'b0;
      lamp_n_reg   <= 2'h0;
      cc_sel_reg   <= 2'h0;
      cv_sel_reg   <= 2'h0;
    end else if (!strap_ok_reg) begin
      strap_ok_reg <= 1'b1;
      lamp_n_reg   <= sync2_reg[5:4];
      cc_sel_reg   <= sync2_reg[3:2];
      cv_sel_reg   <= sync2_reg[1:0];
    end
  end

  logic [12:0] vbat_reg;
  logic [6:0]  cap_reg;
  logic [10:0] ntc_reg;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      vbat_reg <= 13'h0;
      cap_reg  <= 7'h0;
      ntc_reg  <= 11'h0;
    end else begin
      vbat_reg <= vbat_mv_in;
      cap_reg  <= cap_pct_in;
      ntc_reg  <= ntc_mv_in;
    end
  end

  // apb register file
  logic [1:0]  ctrl_reg;
  logic [9:0]  limit_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  wire logic   acc      = psel_in && penable_in;
  wire logic   a_ctrl   = paddr_in == `CSL_A_CTRL;
  wire logic   a_limit  = paddr_in == `CSL_A_LIMIT;
  wire logic   a_status = paddr_in == `CSL_A_STATUS;
  wire logic   a_map    = a_ctrl || a_limit || a_status;
  wire logic   wr_done  = acc && pready_reg && pwrite_in;
  logic [31:0] status_w;
  logic [31:0] rd_w;
  always_comb begin
    if (a_ctrl) begin
      rd_w = {30'h0, ctrl_reg};
    end else if (a_limit) begin
      rd_w = {22'h0, limit_reg};
    end else if (a_status) begin
      rd_w = status_w;
    end else begin
      rd_w = 32'h0;
    end
  end
  // answer one cycle into the access phase
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= acc && !pready_reg;
      pslverr_reg <= acc && !pready_reg && !a_map;
      prdata_reg  <= (acc && !pready_reg && !pwrite_in) ? rd_w : 32'h0;
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl_reg  <= `CSL_CTRL_RST;
      limit_reg <= `CSL_CC_MAX;
    end else if (wr_done && a_ctrl) begin
      ctrl_reg  <= pwdata_in[1:0];
    end else if (wr_done && a_limit) begin
      limit_reg <= pwdata_in[9:0];
    end
  end
  assign prdata_out  = prdata_reg;
  assign pready_out  = pready_reg;
  assign pslverr_out = pslverr_reg;

  // strap decode of current and target voltage
  function automatic logic [9:0] cc_table(input logic [1:0] s);
    return (s == 2'h0) ? `CSL_CC0_MA : (s == 2'h1) ? `CSL_CC1_MA :
           (s == 2'h2) ? `CSL_CC2_MA : `CSL_CC3_MA;
  endfunction
  function automatic logic [12:0] cv_table(input logic [1:0] s);
    return (s == 2'h0) ? `CSL_CV0_MV : (s == 2'h1) ? `CSL_CV1_MV :
           (s == 2'h2) ? `CSL_CV2_MV : `CSL_CV3_MV;
  endfunction
  // strap current with limit and cap
  wire logic [9:0]  cc_strap  = cc_table(cc_sel_reg);
  wire logic [9:0]  cc_lim1   = (limit_reg < cc_strap) ? limit_reg : cc_strap;
  wire logic [9:0]  cc_lim_ma = (cc_lim1 > `CSL_CC_MAX) ? `CSL_CC_MAX : cc_lim1;
  wire logic [12:0] cv_mv     = cv_table(cv_sel_reg);

  wire logic ntc_chg_stop = ntc_reg > `CSL_NTC_CCOLD || ntc_reg < `CSL_NTC_CHOT;
  wire logic ntc_dis_stop = ntc_reg > `CSL_NTC_DCOLD || ntc_reg < `CSL_NTC_DHOT;
  wire logic chg_ok = strap_ok_reg && vin_ok && ctrl_reg[0] && !ntc_chg_stop;

  // charger phase sequencer
  csl_phase_t phase_reg;
  csl_phase_t phase_next;
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      CSL_OFF: begin
        if (chg_ok) begin
          phase_next = (vbat_reg < `CSL_PRE_MV) ? CSL_PRE : CSL_CC;
        end
      end
      CSL_PRE: begin
        if (vbat_reg > `CSL_PRE_MV) begin
          phase_next = CSL_CC;
        end
      end
      CSL_CC: begin
        if (vbat_reg >= cv_mv - `CSL_CV_MARGIN) begin
          phase_next = CSL_CV;
        end
      end
      CSL_CV: begin
        if (taper) begin
          phase_next = CSL_FULL;
        end
      end
      CSL_FULL: begin
        if (vbat_reg < `CSL_RECHG_MV) begin
          phase_next = (vbat_reg < `CSL_PRE_MV) ? CSL_PRE : CSL_CC;
        end
      end
      default: phase_next = CSL_OFF;
    endcase
    if (!chg_ok) begin
      phase_next = CSL_OFF;
    end
  end

  wire logic [9:0] pre_ma = cc_lim_ma / `CSL_PRE_DIV;
  wire logic       chg_act = phase_reg != CSL_OFF && phase_reg != CSL_FULL;
  logic [9:0] cur_next;
  always_comb begin
    if (phase_reg == CSL_PRE) begin
      cur_next = pre_ma;
    end else if (chg_act) begin
      cur_next = cc_lim_ma;
    end else begin
      cur_next = 10'h0;
    end
  end

  // power path hysteresis between 3.1 V and 3.3 V
  logic path_both_reg;
  wire logic path_both_next = (vbat_reg > `CSL_BOTH_MV) ? 1'b1 :
                              (vbat_reg < `CSL_PRIO_MV) ? 1'b0 : path_both_reg;
  wire logic boost_next = ctrl_reg[1] && !fault_any && !ntc_dis_stop &&
                          !(chg_act && !path_both_reg);

  logic [9:0] cur_reg;
  logic       boost_reg;
  logic       chg_en_reg;
  logic [12:0] cv_reg;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      phase_reg     <= CSL_OFF;
      cur_reg       <= 10'h0;
      boost_reg     <= 1'b0;
      chg_en_reg    <= 1'b0;
      path_both_reg <= 1'b0;
      cv_reg        <= `CSL_CV0_MV;
    end else begin
      phase_reg     <= phase_next;
      cur_reg       <= cur_next;
      boost_reg     <= boost_next;
      chg_en_reg    <= chg_act;
      path_both_reg <= path_both_next;
      cv_reg        <= cv_mv;
    end
  end
  assign charge_phase_out      = phase_reg;
  assign charge_current_ma_out = cur_reg;
  assign boost_en_out          = boost_reg;
  assign charge_en_out         = chg_en_reg;
  assign cv_target_mv_out      = cv_reg;

  logic [25:0] blink_cnt_reg;
  logic        b1_reg;
  logic        b05_reg;
  wire logic   half_end = blink_cnt_reg == 26'(BLINK_HALF_CYCLES - 1);
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      blink_cnt_reg <= 26'h0;
      b1_reg        <= 1'b0;
      b05_reg       <= 1'b0;
    end else if (half_end) begin
      blink_cnt_reg <= 26'h0;
      b1_reg        <= !b1_reg;
      b05_reg       <= b1_reg ? !b05_reg : b05_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 26'h1;
    end
  end

  // lamp pattern per detected lamp count
  function automatic logic [3:0] lamp_map(input logic [1:0] n, input logic chg,
      input logic full, input logic dis, input logic [6:0] c,
      input logic b05, input logic b1);
    logic [3:0] m;
    logic [2:0] band;
    logic [2:0] lit;
    logic       low;
    m    = 4'h0;
    low  = c < `CSL_P3;
    band = 3'h0;
    lit  = 3'h0;
    if (n == 2'h3) begin
      band = (c >= `CSL_P75) ? 3'h3 : (c >= `CSL_P50) ? 3'h2 :
             (c >= `CSL_P25) ? 3'h1 : 3'h0;
      lit  = (c >= `CSL_P75) ? 3'h4 : (c >= `CSL_P50) ? 3'h3 :
             (c >= `CSL_P25) ? 3'h2 : low ? 3'h0 : 3'h1;
    end else begin
      band = (c >= `CSL_P66) ? 3'h2 : (c >= `CSL_P33) ? 3'h1 : 3'h0;
      lit  = (c >= `CSL_P66) ? 3'h3 : (c >= `CSL_P33) ? 3'h2 :
             low ? 3'h0 : 3'h1;
    end
    if (n >= 2'h2) begin
      for (int i = 0; i < 4; i++) begin
        if (chg) begin
          m[i] = full || (i < band) ? 1'b1 : (i == band) ? b05 : 1'b0;
        end else if (dis) begin
          m[i] = i < lit;
        end
      end
      if (!chg && dis && lit == 3'h0) begin
        m[0] = b1;
      end
      if (n == 2'h2) begin
        m[3] = 1'b0;
      end
    end else if (n == 2'h1) begin
      m[0] = chg ? (full ? 1'b1 : b05) : 1'b0;
      m[1] = (!chg && dis) ? (low ? b1 : 1'b1) : 1'b0;
    end else begin
      m[0] = chg ? (full ? 1'b1 : b05) : dis ? (low ? b1 : 1'b1) : 1'b0;
    end
    return m;
  endfunction

  wire logic [3:0] lamp_next = lamp_map(lamp_n_reg, phase_reg != CSL_OFF,
      phase_reg == CSL_FULL, boost_reg, cap_reg, b05_reg, b1_reg);
  logic [3:0] lamp_reg;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      lamp_reg <= 4'h0;
    end else begin
      lamp_reg <= lamp_next;
    end
  end
  assign indicator_lamp_1_out = lamp_reg[0];
  assign indicator_lamp_2_out = lamp_reg[1];
  assign indicator_lamp_3_out = lamp_reg[2];
  assign indicator_lamp_4_out = lamp_reg[3];

  assign status_w = {19'h0, lamp_reg, lamp_n_reg, ntc_dis_stop, ntc_chg_stop,
                     path_both_reg, boost_reg, phase_reg};

  // checks
  property p_pre_cur;
    @(posedge clock_in) disable iff (srst_in)
    phase_reg == CSL_PRE |=> cur_reg == $past(cc_lim_ma) / `CSL_PRE_DIV;
  endproperty
  a_pre_cur: assert property (p_pre_cur) else $error("bad precharge current");
  property p_pre_cc;
    @(posedge clock_in) disable iff (srst_in)
    phase_reg == CSL_PRE && vbat_reg > `CSL_PRE_MV && chg_ok |=> phase_reg == CSL_CC;
  endproperty
  a_pre_cc: assert property (p_pre_cc) else $error("precharge not left");
  property p_cc_cv;
    @(posedge clock_in) disable iff (srst_in)
    phase_reg == CSL_CC && chg_ok && vbat_reg >= cv_mv - `CSL_CV_MARGIN
      |=> phase_reg == CSL_CV;
  endproperty
  a_cc_cv: assert property (p_cc_cv) else $error("cv not entered");
  property p_rechg;
    @(posedge clock_in) disable iff (srst_in)
    phase_reg == CSL_FULL && chg_ok && vbat_reg < `CSL_RECHG_MV
      |=> phase_reg inside {CSL_PRE, CSL_CC};
  endproperty
  a_rechg: assert property (p_rechg) else $error("no recharge");
  property p_cur_max;
    @(posedge clock_in) disable iff (srst_in)
    charge_current_ma_out <= `CSL_CC_MAX && charge_current_ma_out <= $past(limit_reg);
  endproperty
  a_cur_max: assert property (p_cur_max) else $error("current over limit");
  property p_prio;
    @(posedge clock_in) disable iff (srst_in)
    chg_act && !path_both_reg |=> !boost_en_out;
  endproperty
  a_prio: assert property (p_prio) else $error("boost during priority charge");
  property p_ntc_chg;
    @(posedge clock_in) disable iff (srst_in)
    ntc_chg_stop |=> phase_reg == CSL_OFF ##1 !charge_en_out;
  endproperty
  a_ntc_chg: assert property (p_ntc_chg) else $error("charge in bad temp");
  property p_ntc_dis;
    @(posedge clock_in) disable iff (srst_in)
    ntc_dis_stop || fault_any |=> !boost_en_out;
  endproperty
  a_ntc_dis: assert property (p_ntc_dis) else $error("boost not stopped");
  property p_blink;
    @(posedge clock_in) disable iff (srst_in)
    $changed(b05_reg) |-> $fell(b1_reg);
  endproperty
  a_blink: assert property (p_blink) else $error("blink out of phase");
  property p_bar4;
    @(posedge clock_in) disable iff (srst_in)
    lamp_n_reg == 2'h3 && phase_reg == CSL_OFF && boost_reg && cap_reg >= `CSL_P75
      |=> lamp_reg == 4'hf;
  endproperty
  a_bar4: assert property (p_bar4) else $error("four lamp bar wrong");
endmodule // csl_top
